// *** core/tap_params.svh ***
/*
  constants of the boundary scan test port: opcodes, register sizes, reset values.
  assumes inclusion by bare name from the package and the design files.
*/
`ifndef TAP_PARAMS_SVH
`define TAP_PARAMS_SVH

// ----------------------------------------
// instruction codes
// ----------------------------------------
`define IR_WIDTH 3
`define OP_EXTEST 3'h0
`define OP_IDCODE 3'h1
`define OP_HIZ_SAMPLE 3'h2
`define OP_SAMPLE_PRELOAD 3'h4
`define OP_BYPASS 3'h7
`define IR_CAPTURE_PATTERN 2'h1

// ----------------------------------------
// register sizes and reset values
// ----------------------------------------
`define ID_WIDTH 32
`define BSR_LEN_NARROW 89
`define BSR_LEN_WIDE 138
`define RESET_TMS_EDGES 5
// identification word: arbitrary neutral value, bit 0 set as presence marker
`define ID_WORD_DEFAULT 32'h0A5A5001
`define OE_CELL_RESET 1'b1

`endif

// *** core/tap_pkg.sv ***
/*
  types shared by the boundary scan test port.
  assumes tap_params.svh for the constants.
*/
`include "tap_params.svh"

package tap_pkg;
  typedef enum logic [3:0] {
    test_logic_reset, run_idle,
    select_dr, capture_dr, shift_dr, exit1_dr, pause_dr, exit2_dr, update_dr,
    select_ir, capture_ir, shift_ir, exit1_ir, pause_ir, exit2_ir, update_ir
  } tap_state_t;
endpackage

// *** core/tap_fsm.sv ***
/*
  sixteen-state test access port controller, clocked by the test clock.
  assumes tms is already synchronous to tck (it is sampled on the rising edge).
*/
`timescale 1ns/1ps
`include "tap_params.svh"

module tap_fsm (
  // test clock and power-up reset
  input wire logic tck,
  input wire logic reset,
  // mode select
  input wire logic tms,
  // current state
  output tap_pkg::tap_state_t state
);

  // ----------------------------------------
  // state transitions
  // ----------------------------------------
  always_ff @(posedge tck) begin
    if (reset) begin
      state <= tap_pkg::test_logic_reset;
    end else begin
      unique case (state)
        tap_pkg::test_logic_reset: state <= tms ? tap_pkg::test_logic_reset : tap_pkg::run_idle;
        tap_pkg::run_idle: state <= tms ? tap_pkg::select_dr : tap_pkg::run_idle;
        tap_pkg::select_dr: state <= tms ? tap_pkg::select_ir : tap_pkg::capture_dr;
        tap_pkg::capture_dr: state <= tms ? tap_pkg::exit1_dr : tap_pkg::shift_dr;
        tap_pkg::shift_dr: state <= tms ? tap_pkg::exit1_dr : tap_pkg::shift_dr;
        tap_pkg::exit1_dr: state <= tms ? tap_pkg::update_dr : tap_pkg::pause_dr;
        tap_pkg::pause_dr: state <= tms ? tap_pkg::exit2_dr : tap_pkg::pause_dr;
        tap_pkg::exit2_dr: state <= tms ? tap_pkg::update_dr : tap_pkg::shift_dr;
        tap_pkg::update_dr: state <= tms ? tap_pkg::select_dr : tap_pkg::run_idle;
        // five high tms edges from anywhere reach reset through here
        tap_pkg::select_ir: state <= tms ? tap_pkg::test_logic_reset : tap_pkg::capture_ir;
        tap_pkg::capture_ir: state <= tms ? tap_pkg::exit1_ir : tap_pkg::shift_ir;
        tap_pkg::shift_ir: state <= tms ? tap_pkg::exit1_ir : tap_pkg::shift_ir;
        tap_pkg::exit1_ir: state <= tms ? tap_pkg::update_ir : tap_pkg::pause_ir;
        tap_pkg::pause_ir: state <= tms ? tap_pkg::exit2_ir : tap_pkg::pause_ir;
        tap_pkg::exit2_ir: state <= tms ? tap_pkg::update_ir : tap_pkg::shift_ir;
        tap_pkg::update_ir: state <= tms ? tap_pkg::select_dr : tap_pkg::run_idle;
      endcase
    end
  end

endmodule

// *** core/sram_boundary_scan_tap.sv ***
/*
  boundary scan test port of a synchronous sram: instruction, bypass, id and
  boundary registers, the output-bus enable cell and the tdo driver.
  assumes tck is the link clock, pins come in on clk from another domain, and
  the core reset is synchronous on clk; tck is assumed free running while reset.
*/
// How it works
// - one bypass bit between tdi and tdo, cleared on capture under bypass
// - capture-dr loads all input and i/o cell values under boundary instructions
// - boundary shift takes tdi into the msb, tdo from the lsb
// - idcode: capture loads the fixed 32-bit word and shifts it out
// - three-bit instruction register, eight codes, three reserved
// - 000 extest, 001 idcode, 010 hi-z sample, 100 sample/preload, 111 bypass
// - shifted instruction becomes current only at update-ir
// - power up and test-logic-reset make idcode current
// - capture-ir loads 01 into the two low instruction shift bits
// - hi-z sample selects boundary path and floats sram outputs
// - sample/preload snapshots pins at capture-dr, sram runs undisturbed
// - shift in preload while shifting out capture; latch at update-dr
// - bypass in shift-dr routes tdi to tdo through one stage
// - extest drives preloaded cell values onto pins, boundary path selected
// - output-enable cell at the top bit; under extest one drives bus, zero floats it
// - enable cell presets to one at power up and in test-logic-reset
// - tms and tdi on rising tck, tdo on falling; five high tms resets
`timescale 1ns/1ps
`include "tap_params.svh"

module sram_boundary_scan_tap #(
  parameter int BSR_LEN = `BSR_LEN_WIDE,
  parameter logic [`ID_WIDTH-1:0] ID_WORD = `ID_WORD_DEFAULT
) (
  // core clock and power-up reset
  input wire logic clk,
  input wire logic reset,
  // test port
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // sram pin ring, sampled and driven
  input wire logic [BSR_LEN-2:0] pin_sense,
  output logic [BSR_LEN-2:0] test_drive,
  output logic test_mode,
  output logic out_bus_oe,
  output logic out_bus_hiz
);

  // ----------------------------------------
  // reset into the tck domain
  // ----------------------------------------
  // registered on clk first so the crossing starts from a single flop
  logic reset_q;
  always_ff @(posedge clk) begin
    reset_q <= reset;
  end

  // the power-up reset is carried to tck by two flip-flops
  logic rst_meta;
  logic rst_tck;
  always_ff @(posedge tck) begin
    rst_meta <= reset_q;
    rst_tck <= rst_meta;
  end

  // ----------------------------------------
  // pin ring into the tck domain
  // ----------------------------------------
  // pins change on the sram clock; values caught mid-edge are not guaranteed
  logic [BSR_LEN-2:0] pin_meta;
  logic [BSR_LEN-2:0] pin_sync;
  always_ff @(posedge tck) begin
    pin_meta <= pin_sense;
    pin_sync <= pin_meta;
  end

  // ----------------------------------------
  // controller
  // ----------------------------------------
  tap_pkg::tap_state_t state;
  tap_fsm u_fsm (
    .tck(tck),
    .reset(rst_tck),
    .tms(tms),
    .state(state)
  );

  logic tlr;
  assign tlr = rst_tck || state == tap_pkg::test_logic_reset;

  // ----------------------------------------
  // instruction register
  // ----------------------------------------
  logic [`IR_WIDTH-1:0] ir_shift;
  logic [`IR_WIDTH-1:0] ir_cur;

  always_ff @(posedge tck) begin
    if (state == tap_pkg::capture_ir) begin
      ir_shift <= {1'b0, `IR_CAPTURE_PATTERN};
    end else if (state == tap_pkg::shift_ir) begin
      ir_shift <= {tdi, ir_shift[`IR_WIDTH-1:1]};
    end
  end

  // reserved codes are stored and decode as bypass; the controller avoids them
  always_ff @(posedge tck) begin
    if (tlr) begin
      ir_cur <= `OP_IDCODE;
    end else if (state == tap_pkg::update_ir) begin
      ir_cur <= ir_shift;
    end
  end

  function automatic logic uses_bsr(input logic [`IR_WIDTH-1:0] op);
    return op == `OP_EXTEST || op == `OP_HIZ_SAMPLE || op == `OP_SAMPLE_PRELOAD;
  endfunction

  logic sel_bsr;
  logic sel_id;
  logic sel_byp;
  assign sel_bsr = uses_bsr(ir_cur);
  assign sel_id = ir_cur == `OP_IDCODE;
  assign sel_byp = !sel_bsr && !sel_id;

  // ----------------------------------------
  // bypass and id registers
  // ----------------------------------------
  logic bypass_bit;
  always_ff @(posedge tck) begin
    if (state == tap_pkg::capture_dr) begin
      bypass_bit <= 1'b0;
    end else if (state == tap_pkg::shift_dr && sel_byp) begin
      bypass_bit <= tdi;
    end
  end

  logic [`ID_WIDTH-1:0] id_shift;
  always_ff @(posedge tck) begin
    if (state == tap_pkg::capture_dr && sel_id) begin
      id_shift <= ID_WORD;
    end else if (state == tap_pkg::shift_dr && sel_id) begin
      id_shift <= {tdi, id_shift[`ID_WIDTH-1:1]};
    end
  end

  // ----------------------------------------
  // boundary scan register
  // ----------------------------------------
  // top cell is the output-bus enable, the rest map one per bump
  logic [BSR_LEN-1:0] bsr_shift;
  logic [BSR_LEN-1:0] bsr_latch;

  always_ff @(posedge tck) begin
    if (state == tap_pkg::capture_dr && sel_bsr) begin
      bsr_shift <= {bsr_latch[BSR_LEN-1], pin_sync};
    end else if (state == tap_pkg::shift_dr && sel_bsr) begin
      bsr_shift <= {tdi, bsr_shift[BSR_LEN-1:1]};
    end
  end

  always_ff @(posedge tck) begin
    if (tlr) begin
      bsr_latch <= {`OE_CELL_RESET, {(BSR_LEN-1){1'b0}}};
    end else if (state == tap_pkg::update_dr && sel_bsr) begin
      bsr_latch <= bsr_shift;
    end
  end

  // ----------------------------------------
  // pin control, registered on tck
  // ----------------------------------------
  // sample/preload and idcode leave the sram alone
  always_ff @(posedge tck) begin
    if (tlr) begin
      test_mode <= 1'b0;
      test_drive <= '0;
      out_bus_oe <= 1'b0;
      out_bus_hiz <= 1'b0;
    end else begin
      test_mode <= ir_cur == `OP_EXTEST;
      test_drive <= bsr_latch[BSR_LEN-2:0];
      out_bus_oe <= ir_cur == `OP_EXTEST && bsr_latch[BSR_LEN-1];
      out_bus_hiz <= ir_cur == `OP_HIZ_SAMPLE || (ir_cur == `OP_EXTEST && !bsr_latch[BSR_LEN-1]);
    end
  end

  // ----------------------------------------
  // tdo on the falling edge
  // ----------------------------------------
  logic next_tdo;
  always_comb begin
    if (state == tap_pkg::shift_ir) begin
      next_tdo = ir_shift[0];
    end else if (sel_bsr) begin
      next_tdo = bsr_shift[0];
    end else if (sel_id) begin
      next_tdo = id_shift[0];
    end else begin
      next_tdo = bypass_bit;
    end
  end

  always_ff @(negedge tck) begin
    if (rst_tck) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo <= next_tdo;
      tdo_oe <= state == tap_pkg::shift_ir || state == tap_pkg::shift_dr;
    end
  end

endmodule

// *** testbench/tap_chk.sv ***
/* pin-level checker of the scan port.
   assumes a bind onto the port's top module */
`timescale 1ns/1ps
module tap_chk #(
  parameter int BSR_LEN = 138
) (
  // link clock and reset
  input wire logic tck,
  input wire logic reset,
  // port and pin ring
  input wire logic tms,
  input wire logic tdo_oe,
  input wire logic [BSR_LEN-2:0] test_drive,
  input wire logic test_mode,
  input wire logic out_bus_oe,
  input wire logic out_bus_hiz
);
  // ------
  // checks
  // ------
  default clocking @(posedge tck); endclocking
  default disable iff (reset);
  sequence s_five; tms [*5]; endsequence
  chk_bus_mode: assert property (out_bus_oe |-> test_mode) else $error("bus driven off extest");
  chk_bus_excl: assert property (!(out_bus_oe && out_bus_hiz)) else $error("bus oe with hiz");
  chk_tlr_entry: assert property (s_five |-> ##[1:2] !test_mode && !tdo_oe && !out_bus_hiz)
    else $error("five ones did not reset");
  chk_shift_in: assert property ($rose(tdo_oe) |-> !$past(tms)) else $error("shift entered on tms high");
  chk_shift_out: assert property ($fell(tdo_oe) |-> $past(tms)) else $error("shift left on tms low");
  chk_ir_update: assert property ($changed(test_mode) |-> !tdo_oe && !$past(tdo_oe))
    else $error("mode changed while shifting");
  chk_latch_upd: assert property ($changed(test_drive) |-> !tdo_oe && !$past(tdo_oe))
    else $error("pins changed while shifting");
  chk_reset_exit: assert property ($fell(reset) |-> !test_mode && !out_bus_hiz) else $error("bad mode at reset");
endmodule
bind sram_boundary_scan_tap tap_chk #(.BSR_LEN(BSR_LEN)) chk_u (.tck(tck), .reset(reset), .tms(tms),
  .tdo_oe(tdo_oe), .test_drive(test_drive), .test_mode(test_mode), .out_bus_oe(out_bus_oe), .out_bus_hiz(out_bus_hiz));

// *** testbench/jtag_ctl.sv ***
/* board test controller model driving the scan port.
   assumes the device samples on rising tck, answers on falling tck */
`timescale 1ns/1ps
module jtag_ctl (
  // toward the device
  output logic tck,
  output logic tms,
  output logic tdi,
  // serial answer
  input wire logic tdo,
  input wire logic tdo_oe
);
  // ----------
  // test clock
  // ----------
  logic run = 1'b1;
  // parks low between frames; offset keeps its edges off the core clock's
  initial begin
    tck = 1'b0;
    #4;
    forever #15 tck = run ? !tck : 1'b0;
  end
  // lines are pulled up when idle
  initial tms = 1'b1;
  initial tdi = 1'b1;
  task automatic step(input logic m, input logic d, output logic o);
    @(negedge tck);
    tms <= m;
    tdi <= d;
    @(posedge tck);
    // floating tdo reads as unknown
    o = tdo_oe ? tdo : 1'bx;
  endtask
  task automatic moves(input logic [7:0] seq, input int n);
    logic o;
    for (int i = 0; i < n; i++) step(seq[i], 1'b1, o);
  endtask
  task automatic tlr();
    moves(8'h1F, 6);
    moves(8'h00, 1);
  endtask
  task automatic scan(input logic ir, input int n, input logic [255:0] din, output logic [255:0] dout);
    logic [255:0] d;
    d = din;
    // a reserved opcode is never loaded; bypass goes out in its place
    if (ir && (din[2:0] == 3'h3 || din[2:0] == 3'h5 || din[2:0] == 3'h6)) d[2:0] = 3'h7;
    dout = '0;
    moves(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
    for (int i = 0; i < n; i++) step(i == n - 1, d[i], dout[i]);
    moves(8'h01, 3);
  endtask
endmodule

// *** testbench/sram_boundary_scan_tap_bench.sv ***
/* self-checking bench of the scan port.
   assumes jtag_ctl as the far side and the wide ring */
`timescale 1ns/1ps
module sram_boundary_scan_tap_bench;
  localparam int L = 138;
  // arbitrary identification value
  localparam logic [31:0] IDW = 32'h1357_9BDF;
  localparam logic [159:0] PAT_A = {5{32'hC3A5_5A3C}};
  localparam logic [159:0] PAT_S = {5{32'h9E61_27D8}};
  logic clk, reset, tck, tms, tdi, tdo, tdo_oe, test_mode, out_bus_oe, out_bus_hiz;
  logic [L-2:0] pin_sense, test_drive, pa, pb;
  logic [255:0] got;
  int n_fail = 0;
  int cmp_count = 0;
  sram_boundary_scan_tap #(.BSR_LEN(L), .ID_WORD(IDW)) dut_u (.clk(clk), .reset(reset), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pin_sense(pin_sense), .test_drive(test_drive),
    .test_mode(test_mode), .out_bus_oe(out_bus_oe), .out_bus_hiz(out_bus_hiz));
  jtag_ctl ctl_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
  // -------
  // helpers
  // -------
  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic pins(input logic m, input logic oe, input logic hz);
    ctl_u.moves(8'h00, 2);
    check(256'({test_mode, out_bus_oe, out_bus_hiz}), 256'({m, oe, hz}));
  endtask
  task automatic done(input string name);
    $display("test %s over", name);
    ctl_u.run = 1'b0;
    #100;
    ctl_u.run = 1'b1;
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ---------
  // scenarios
  // ---------
  task automatic t_idcode();
    ctl_u.tlr();
    ctl_u.scan(0, 32, '1, got);
    check(got, {224'h0, IDW});
    done("idcode");
  endtask
  task automatic t_bypass();
    ctl_u.scan(1, 3, 256'h7, got);
    check(got, 256'h1);
    ctl_u.scan(0, 4, 256'hD, got);
    check(got, 256'hA);
    ctl_u.scan(1, 3, 256'h1, got);
    check(got, 256'h1);
    ctl_u.scan(0, 4, 256'hD, got);
    check(got, {252'h0, IDW[3:0]});
    pins(0, 0, 0);
    done("bypass");
  endtask
  task automatic t_sample();
    ctl_u.scan(1, 3, 256'h4, got);
    ctl_u.scan(0, L, 256'({1'b0, pa}), got);
    check(got, 256'({1'b1, pin_sense}));
    pins(0, 0, 0);
    check(256'(test_drive), 256'(pa));
    done("sample");
  endtask
  task automatic t_extest();
    ctl_u.scan(1, 3, 256'h0, got);
    pins(1, 0, 1);
    ctl_u.scan(0, L, 256'({1'b1, pb}), got);
    check(got, 256'({1'b0, pin_sense}));
    pins(1, 1, 0);
    check(256'(test_drive), 256'(pb));
    done("extest");
  endtask
  task automatic t_hiz();
    ctl_u.scan(1, 3, 256'h2, got);
    pins(0, 0, 1);
    ctl_u.scan(0, L, 256'({1'b0, pa}), got);
    check(got, 256'({1'b1, pin_sense}));
    pins(0, 0, 1);
    ctl_u.tlr();
    pins(0, 0, 0);
    ctl_u.scan(1, 3, 256'h0, got);
    pins(1, 1, 0);
    done("hiz");
  endtask
  // ----
  // main
  // ----
  initial begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  initial begin
    repeat (50000) @(posedge clk);
    n_fail++;
    $display("BAD %0t run too long", $time);
    print_verdict();
  end
  initial begin
    reset = 1'b1;
    pa = PAT_A[L-2:0];
    pb = ~pa;
    pin_sense = PAT_S[L-2:0];
    repeat (5) @(posedge tck);
    @(posedge clk);
    reset <= 1'b0;
    t_idcode();
    t_bypass();
    t_sample();
    @(posedge clk);
    pin_sense <= ~pin_sense;
    t_extest();
    t_hiz();
    print_verdict();
  end
endmodule
